// *** rtl/pcims_core.v ***
// pcims_core.v: master and target signalling for a 64-bit parallel bus
// assumes the arbiter grant is handled outside; one bus clock on mclk
`timescale 1ns/100ps
`include "pcims_map.vh"
// Functional notes
// - cbe carries command, then byte enables
// - byte enables steady through data phase
// - low parity covers ad31:0 and cbe3:0
// - high parity covers ad63:32 and cbe7:4
// - address parity valid one clock later
// - data parity one clock after ready
// - parity held until phase completes plus one
// - master drives parity addr/write; target read
// - frame asserted until final data phase
// - phase completes when both readies sampled
// - initiator ready: write data or read acceptance
// - target ready: read data or write acceptance
// - target stop; master ends on stop
// - idsel selects config accesses only
// - target claims with devsel; master samples
// - address phase is first frame clock
// - 32-bit bus excludes upper half
// - nothing driven while reset asserted
// - sustained signals driven high before release
module pcims_core #(
  parameter [63:0] BAR_BASE = 64'h0000000000000000,
  parameter BAR_BITS = 12 // size of decoded window in address bits
) (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  input wire bus64, // high when attached to a 64-bit bus
  // master request side (same-clock logic)
  input wire mreq_valid,
  input wire [3:0] mreq_cmd,
  input wire [63:0] mreq_addr,
  input wire [63:0] mreq_wdata,
  input wire [7:0] mreq_be_n,
  input wire mreq_last,
  output wire mreq_ready,
  output reg [63:0] mrsp_rdata_reg,
  output reg mrsp_valid_reg,
  output reg mrsp_abort_reg,
  // target user side
  input wire [63:0] tgt_rdata,
  input wire tgt_stop_req,
  output reg [63:0] tgt_wdata_reg,
  output reg [7:0] tgt_be_n_reg,
  output reg tgt_wvalid_reg,
  output reg tgt_cfg_reg,
  // address/data and command pins
  input wire [63:0] ad_i,
  output reg [63:0] ad_o,
  output reg ad_lo_oe,
  output reg ad_hi_oe,
  input wire [7:0] cbe_n_i,
  output reg [7:0] cbe_n_o,
  output reg cbe_lo_oe,
  output reg cbe_hi_oe,
  // parity pins
  input wire par_i,
  output reg par_o,
  output reg par_oe,
  input wire par64_i,
  output reg par64_o,
  output reg par64_oe,
  // control pins, active low except idsel
  input wire frame_n_i,
  output reg frame_n_o,
  output reg frame_oe,
  input wire irdy_n_i,
  output reg irdy_n_o,
  output reg irdy_oe,
  input wire trdy_n_i,
  output reg trdy_n_o,
  output reg trdy_oe,
  input wire stop_n_i,
  output reg stop_n_o,
  output reg stop_oe,
  input wire devsel_n_i,
  output reg devsel_n_o,
  output reg devsel_oe,
  input wire idsel_i
);
  // three-stage control pin synchronisers, two stages for ad and cbe (per house practice)
  reg [2:0] fr_s, ir_s, tr_s, st_s, dv_s, id_s;
  reg [63:0] ad_s1, ad_s2;
  reg [7:0] cb_s1, cb_s2;
  wire frame_a = ~fr_s[1]; // second stage used, with no agreement check
  wire irdy_a = ~ir_s[1];
  wire trdy_a = ~tr_s[1];
  wire stop_a = ~st_s[1];
  wire devsel_a = ~dv_s[1];
  wire idsel_a = id_s[1];
  reg frame_d_reg; // previous frame level for edge
  // state
  reg [2:0] mst_reg, tst_reg;
  reg mwrite_reg; // current master access is a write
  reg twrite_reg; // current target access is a write
  reg [2:0] dv_wait_reg; // devsel timeout counter
  // parity sources
  wire pl, ph;

  // third stage reloads only an equal second stage, so it keeps its reset level
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fr_s <= 3'h7; ir_s <= 3'h7; tr_s <= 3'h7; st_s <= 3'h7; dv_s <= 3'h7; id_s <= 3'h0;
      ad_s1 <= 64'h0000000000000000; ad_s2 <= 64'h0000000000000000;
      cb_s1 <= `PCIMS_BE_NONE; cb_s2 <= `PCIMS_BE_NONE;
    end else begin
      fr_s <= (fr_s[1] == fr_s[2]) ? {fr_s[1], fr_s[0], frame_n_i} : {fr_s[2], fr_s[0], frame_n_i};
      ir_s <= (ir_s[1] == ir_s[2]) ? {ir_s[1], ir_s[0], irdy_n_i} : {ir_s[2], ir_s[0], irdy_n_i};
      tr_s <= (tr_s[1] == tr_s[2]) ? {tr_s[1], tr_s[0], trdy_n_i} : {tr_s[2], tr_s[0], trdy_n_i};
      st_s <= (st_s[1] == st_s[2]) ? {st_s[1], st_s[0], stop_n_i} : {st_s[2], st_s[0], stop_n_i};
      dv_s <= (dv_s[1] == dv_s[2]) ? {dv_s[1], dv_s[0], devsel_n_i} : {dv_s[2], dv_s[0], devsel_n_i};
      id_s <= (id_s[1] == id_s[2]) ? {id_s[1], id_s[0], idsel_i} : {id_s[2], id_s[0], idsel_i};
      ad_s1 <= ad_i; ad_s2 <= ad_s1;
      cb_s1 <= cbe_n_i; cb_s2 <= cb_s1;
    end
  end

  // lane levels as they stand: host lanes count when we drive only ad (target read)
  wire [7:0] cbe_seen = {cbe_hi_oe ? cbe_n_o[7:4] : cbe_n_i[7:4], cbe_lo_oe ? cbe_n_o[3:0] : cbe_n_i[3:0]};

  // parity over whatever this block drives this clock
  pcims_parity #(.DW(32), .CW(4)) u_par_lo (
    .ad_half(ad_o[31:0]),
    .cbe_half(cbe_seen[3:0]),
    .par_bit(pl)
  );
  pcims_parity #(.DW(32), .CW(4)) u_par_hi (
    .ad_half(ad_o[63:32]),
    .cbe_half(cbe_seen[7:4]),
    .par_bit(ph)
  );

  // address phase = first clock frame seen low
  wire addr_phase = frame_a & ~frame_d_reg & (mst_reg == `PCIMS_M_IDLE);
  wire hit_mem = (ad_s2[63:BAR_BITS] == BAR_BASE[63:BAR_BITS]) &&
                 (cb_s2[3:0] == `PCIMS_CMD_MEM_RD || cb_s2[3:0] == `PCIMS_CMD_MEM_WR);
  // idsel only counts for config cycles
  wire hit_cfg = idsel_a && (cb_s2[3:0] == `PCIMS_CMD_CFG_RD || cb_s2[3:0] == `PCIMS_CMD_CFG_WR);
  wire t_done = irdy_a & trdy_n_o == 1'b0;
  wire m_done = ~irdy_n_o & trdy_a;
  assign mreq_ready = (mst_reg == `PCIMS_M_IDLE) && (tst_reg == `PCIMS_T_IDLE) && !frame_a;

  // master and target sequencing; outputs float under reset
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mst_reg <= `PCIMS_M_IDLE; tst_reg <= `PCIMS_T_IDLE;
      frame_d_reg <= 1'b0; mwrite_reg <= 1'b0; twrite_reg <= 1'b0; dv_wait_reg <= 3'h0;
      ad_o <= 64'h0000000000000000; ad_lo_oe <= 1'b0; ad_hi_oe <= 1'b0;
      cbe_n_o <= `PCIMS_BE_NONE; cbe_lo_oe <= 1'b0; cbe_hi_oe <= 1'b0;
      par_o <= 1'b0; par_oe <= 1'b0; par64_o <= 1'b0; par64_oe <= 1'b0;
      frame_n_o <= 1'b1; frame_oe <= 1'b0; irdy_n_o <= 1'b1; irdy_oe <= 1'b0;
      trdy_n_o <= 1'b1; trdy_oe <= 1'b0; stop_n_o <= 1'b1; stop_oe <= 1'b0;
      devsel_n_o <= 1'b1; devsel_oe <= 1'b0;
      mrsp_rdata_reg <= 64'h0000000000000000; mrsp_valid_reg <= 1'b0; mrsp_abort_reg <= 1'b0;
      tgt_wdata_reg <= 64'h0000000000000000; tgt_be_n_reg <= `PCIMS_BE_NONE;
      tgt_wvalid_reg <= 1'b0; tgt_cfg_reg <= 1'b0;
    end else begin
      frame_d_reg <= frame_a;
      mrsp_valid_reg <= 1'b0;
      mrsp_abort_reg <= 1'b0;
      tgt_wvalid_reg <= 1'b0;
      // parity follows driven lines by one clock
      par_o <= pl;
      par64_o <= ph;
      // parity driven one clock after we drove ad
      par_oe <= ad_lo_oe;
      par64_oe <= ad_hi_oe & bus64;
      case (mst_reg)
        `PCIMS_M_IDLE: begin
          if (mreq_ready && mreq_valid) begin
            // address phase: command on cbe
            frame_n_o <= 1'b0; frame_oe <= 1'b1;
            ad_o <= mreq_addr; ad_lo_oe <= 1'b1; ad_hi_oe <= bus64;
            cbe_n_o <= {4'hF, mreq_cmd}; cbe_lo_oe <= 1'b1; cbe_hi_oe <= bus64;
            mwrite_reg <= mreq_cmd[0];
            dv_wait_reg <= 3'h0;
            mst_reg <= `PCIMS_M_ADDR;
          end
        end
        `PCIMS_M_ADDR: begin
          // data phase: byte enables, held for the phase
          cbe_n_o <= bus64 ? mreq_be_n : {4'hF, mreq_be_n[3:0]};
          irdy_n_o <= 1'b0; irdy_oe <= 1'b1;
          if (mwrite_reg) ad_o <= bus64 ? mreq_wdata : {`PCIMS_HI_ZERO, mreq_wdata[31:0]};
          else begin ad_lo_oe <= 1'b0; ad_hi_oe <= 1'b0; end
          if (mreq_last) frame_n_o <= 1'b1; // single phase: final
          mst_reg <= `PCIMS_M_DATA;
        end
        `PCIMS_M_DATA: begin
          dv_wait_reg <= devsel_a ? dv_wait_reg : dv_wait_reg + 3'h1;
          if (m_done || stop_a || dv_wait_reg == 3'h7) begin
            // stop or no claimant ends the transfer
            mrsp_valid_reg <= m_done;
            mrsp_abort_reg <= ~devsel_a;
            mrsp_rdata_reg <= ad_s2;
            irdy_n_o <= 1'b1; frame_n_o <= 1'b1; // drive high before release
            ad_lo_oe <= 1'b0; ad_hi_oe <= 1'b0; cbe_lo_oe <= 1'b0; cbe_hi_oe <= 1'b0;
            mst_reg <= `PCIMS_M_PARK;
          end
        end
        `PCIMS_M_PARK: begin
          frame_oe <= 1'b0; irdy_oe <= 1'b0; // release after high clock
          mst_reg <= `PCIMS_M_TURN;
        end
        `PCIMS_M_TURN: mst_reg <= `PCIMS_M_IDLE; // one idle clock before reuse
        default: mst_reg <= `PCIMS_M_IDLE;
      endcase
      case (tst_reg)
        `PCIMS_T_IDLE: begin
          if (addr_phase && (hit_mem || hit_cfg)) begin
            // claim the access
            devsel_n_o <= 1'b0; devsel_oe <= 1'b1;
            trdy_n_o <= 1'b0; trdy_oe <= 1'b1;
            stop_n_o <= ~tgt_stop_req; stop_oe <= 1'b1;
            twrite_reg <= cb_s2[0];
            tgt_cfg_reg <= hit_cfg;
            if (!cb_s2[0]) begin
              ad_o <= tgt_rdata; ad_lo_oe <= 1'b1; ad_hi_oe <= bus64; // read data
            end
            tst_reg <= `PCIMS_T_DATA;
          end
        end
        `PCIMS_T_DATA: begin
          if (t_done) begin
            tgt_wdata_reg <= ad_s2; tgt_be_n_reg <= cb_s2; tgt_wvalid_reg <= twrite_reg;
            if (!frame_a || !stop_n_o) begin
              devsel_n_o <= 1'b1; trdy_n_o <= 1'b1; stop_n_o <= 1'b1;
              ad_lo_oe <= 1'b0; ad_hi_oe <= 1'b0;
              tst_reg <= `PCIMS_T_PARK;
            end else if (!twrite_reg) ad_o <= tgt_rdata;
          end
        end
        `PCIMS_T_PARK: begin
          devsel_oe <= 1'b0; trdy_oe <= 1'b0; stop_oe <= 1'b0;
          tst_reg <= `PCIMS_T_WAIT;
        end
        `PCIMS_T_WAIT: if (!frame_a) tst_reg <= `PCIMS_T_IDLE;
        default: tst_reg <= `PCIMS_T_IDLE;
      endcase
    end
  end
endmodule // pcims_core

// *** rtl/pcims_map.vh ***
// pcims_map.vh: constants for the bus master/target signalling block
// assumes inclusion by pcims_core.v and the bench; pcims_parity.v does not include it
`ifndef PCIMS_MAP_VH
`define PCIMS_MAP_VH
// bus commands (cbe[3:0] during address phase)
`define PCIMS_CMD_IO_RD 4'h2
`define PCIMS_CMD_IO_WR 4'h3
`define PCIMS_CMD_MEM_RD 4'h6
`define PCIMS_CMD_MEM_WR 4'h7
`define PCIMS_CMD_CFG_RD 4'hA
`define PCIMS_CMD_CFG_WR 4'hB
// master states
`define PCIMS_M_IDLE 3'h0
`define PCIMS_M_ADDR 3'h1
`define PCIMS_M_DATA 3'h2
`define PCIMS_M_PARK 3'h3
`define PCIMS_M_TURN 3'h4
// target states
`define PCIMS_T_IDLE 3'h0
`define PCIMS_T_DATA 3'h1
`define PCIMS_T_PARK 3'h2
`define PCIMS_T_WAIT 3'h3
// all-ones byte enable pattern (no lanes enabled)
`define PCIMS_BE_NONE 8'hFF
`define PCIMS_HI_ZERO 32'h00000000
`endif

// *** rtl/pcims_parity.v ***
// pcims_parity.v: even parity over one half of the ad/cbe bus
// assumes inputs are the values being driven on the lines this clock
`timescale 1ns/100ps
module pcims_parity #(
  parameter DW = 32,
  parameter CW = 4
) (
  // covered lines
  input wire [DW-1:0] ad_half,
  input wire [CW-1:0] cbe_half,
  // parity bit, computed one clock ahead of the pin register
  output wire par_bit
);
  // xor of all covered ones makes the total count even
  assign par_bit = (^ad_half) ^ (^cbe_half);
endmodule // pcims_parity

// *** tb/pcims_chk.sv ***
// pcims_chk.sv: pin-level assertions for the signalling block
// assumes the bench feeds resolved bus levels back on the _i ports
`timescale 1ns/100ps
module pcims_chk (
  // clock, reset, width
  input wire mclk, input wire reset_n, input wire bus64,
  // address/data and command
  input wire [63:0] ad_i, input wire [63:0] ad_o, input wire ad_lo_oe, input wire ad_hi_oe,
  input wire [7:0] cbe_n_i, input wire [7:0] cbe_n_o, input wire cbe_lo_oe, input wire cbe_hi_oe,
  // parity and control
  input wire par_o, input wire par_oe, input wire par64_o, input wire par64_oe,
  input wire frame_n_o, input wire frame_oe, input wire irdy_n_o, input wire irdy_oe,
  input wire trdy_n_o, input wire trdy_oe, input wire devsel_n_o, input wire devsel_oe
);
  // driven pins except cbe_hi_oe, par64_oe and stop_oe; reset must keep all of these low
  wire any_oe = ad_lo_oe | ad_hi_oe | cbe_lo_oe | par_oe | frame_oe | irdy_oe | trdy_oe | devsel_oe;
  wire irdy_on = irdy_oe & ~irdy_n_o; // device holds initiator ready
  wire trdy_on = trdy_oe & ~trdy_n_o; // device holds target ready
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_reset_float: assert property (disable iff (1'b0) !reset_n |-> !any_oe)
    else $error("pin driven during reset");
  a_upper_off: assert property (!bus64 |-> !(ad_hi_oe || cbe_hi_oe || par64_oe))
    else $error("upper half driven on narrow bus");
  a_par_low: assert property (par_oe && $past(ad_lo_oe) |-> par_o == ^{$past(ad_i[31:0]), $past(cbe_n_i[3:0])})
    else $error("low parity wrong");
  a_par_high: assert property (par64_oe && $past(ad_hi_oe) |-> par64_o == ^{$past(ad_i[63:32]), $past(cbe_n_i[7:4])})
    else $error("high parity wrong");
  a_addr_phase: assert property ($fell(frame_n_o) && frame_oe |=> par_oe && irdy_on)
    else $error("no parity or ready after address");
  a_par_hold: assert property ((irdy_on || trdy_on) && ad_lo_oe |=> par_oe)
    else $error("data parity not held");
  a_lanes_steady: assert property (irdy_on && $past(irdy_on) |-> $stable(cbe_n_o) && (!ad_lo_oe || $stable(ad_o)))
    else $error("byte enables moved in data phase");
  a_ready_sel: assert property (trdy_on |-> devsel_oe && !devsel_n_o)
    else $error("target ready without select");
  a_par_owner: assert property (par_oe |-> ad_lo_oe || $past(ad_lo_oe))
    else $error("parity driven for foreign data");
  a_frame_rel: assert property ($fell(frame_oe) |-> $past(frame_n_o))
    else $error("frame floated while low");
  a_irdy_rel: assert property ($fell(irdy_oe) |-> $past(irdy_n_o))
    else $error("initiator ready floated while low");
  a_trdy_rel: assert property ($fell(trdy_oe) |-> $past(trdy_n_o))
    else $error("target ready floated while low");
endmodule // pcims_chk
bind pcims_core pcims_chk u_pcims_chk (.*);

// *** tb/pcims_peer.sv ***
// pcims_peer.sv: behavioural target across the bus from the block
// assumes resolved bus levels in; released control lines read high
`timescale 1ns/100ps
module pcims_peer (
  // bus side
  input wire mclk,
  input wire frame_n,
  input wire irdy_n,
  input wire [63:0] ad,
  input wire [7:0] cbe_n,
  output reg [63:0] ad_p = 64'h0,
  output reg ad_p_oe = 1'b0,
  output reg trdy_n = 1'b1,
  output reg devsel_n = 1'b1,
  // control and capture
  input wire en,
  input wire [3:0] lat,
  input wire [63:0] rdata,
  output reg [63:0] addr = 64'h0,
  output reg [3:0] cmd = 4'h0,
  output reg [63:0] wdata = 64'h0,
  output reg [7:0] be_n = 8'hFF
);
  reg frame_q = 1'b1; // frame a clock ago, finds the address phase
  reg busy = 1'b0;
  reg [3:0] wait_cnt = 4'h0; // wait states, so slow answers are tried too
  // one transfer at a time, no stop
  always @(posedge mclk) begin
    frame_q <= frame_n;
    if (en && frame_q && !frame_n && !busy) begin // first frame clock
      busy <= 1'b1;
      addr <= ad;
      cmd <= cbe_n[3:0]; // command on the low lanes
      wait_cnt <= lat;
    end else if (busy && !trdy_n && !irdy_n) begin // both ready
      busy <= 1'b0;
      trdy_n <= 1'b1; // high for a clock before release
      devsel_n <= 1'b1;
      ad_p_oe <= 1'b0;
      wdata <= ad; // write data with initiator ready
      be_n <= cbe_n;
    end else if (busy) begin
      devsel_n <= 1'b0; // claim
      if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
      else begin
        trdy_n <= 1'b0;
        ad_p_oe <= !cmd[0]; // read data only
        ad_p <= rdata;
      end
    end
  end
endmodule // pcims_peer

// *** tb/testbench.sv ***
// testbench.sv: self-checking bench for the signalling block
// assumes pcims_peer answers device-master cycles; the bench plays host initiator
`timescale 1ns/100ps
`include "pcims_map.vh"
module testbench;
  reg mclk = 1'b0, reset_n = 1'b0, bus64 = 1'b1, mreq_valid = 1'b0, idsel = 1'b0, p_en = 1'b1;
  reg b_frame_n = 1'b1, b_irdy_n = 1'b1, b_ad_oe = 1'b0, par_q = 1'b0, par64_q = 1'b0;
  reg [3:0] mreq_cmd = 4'h0, p_lat = 4'h0;
  reg [63:0] mreq_addr = 64'h0, b_ad = 64'h0, ad_last = 64'h0;
  reg [7:0] b_cbe = 8'hFF; // host lanes, idle all ones
  integer errors = 0, checked = 0, cyc = 0, k;
  localparam [63:0] RDATA = 64'hC3A5_1E7F_0B96_D248, TDATA = 64'h5A17_E2C4_93F0_6B8D;
  wire mreq_ready, mrsp_valid_reg, mrsp_abort_reg, tgt_wvalid_reg, tgt_cfg_reg, ad_lo_oe, ad_hi_oe, cbe_lo_oe;
  wire cbe_hi_oe, par_o, par_oe, par64_o, par64_oe, frame_n_o, frame_oe, irdy_n_o, irdy_oe, trdy_n_o, trdy_oe;
  wire stop_n_o, stop_oe, devsel_n_o, devsel_oe, p_ad_oe, p_trdy_n, p_devsel_n;
  wire [63:0] mrsp_rdata_reg, tgt_wdata_reg, ad_o, p_ad, p_addr, p_wdata;
  wire [7:0] tgt_be_n_reg, cbe_n_o, p_be_n;
  wire [3:0] p_cmd;
  wire [63:0] msk = bus64 ? {64{1'b1}} : 64'h0000_0000_FFFF_FFFF; // narrow bus compares low half
  // bus resolution; a released data line shows the inverse of its last level
  wire [63:0] src = p_ad_oe ? p_ad : b_ad_oe ? b_ad : ~ad_last;
  wire [63:0] ad = {ad_hi_oe ? ad_o[63:32] : src[63:32], ad_lo_oe ? ad_o[31:0] : src[31:0]};
  wire [7:0] cbe = {cbe_hi_oe ? cbe_n_o[7:4] : b_cbe[7:4], cbe_lo_oe ? cbe_n_o[3:0] : b_cbe[3:0]};
  wire frame_n = frame_oe ? frame_n_o : b_frame_n; // control lines pulled up
  wire irdy_n = irdy_oe ? irdy_n_o : b_irdy_n;
  wire trdy_n = trdy_oe ? trdy_n_o : p_trdy_n;
  wire devsel_n = devsel_oe ? devsel_n_o : p_devsel_n;
  always #5 mclk = ~mclk;
  // last levels, partner parity one clock late, and the hang limit
  always @(posedge mclk) begin
    ad_last <= ad;
    par_q <= ^{ad[31:0], cbe[3:0]};
    par64_q <= ^{ad[63:32], cbe[7:4]};
    cyc = cyc + 1;
    if (cyc == 6000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  pcims_core u_pcims_core (.mclk, .reset_n, .bus64, .mreq_valid, .mreq_cmd, .mreq_addr, .mreq_wdata(~mreq_addr),
    .mreq_be_n(mreq_addr[7:0]), .mreq_last(1'b1), .mreq_ready, .mrsp_rdata_reg, .mrsp_valid_reg, .mrsp_abort_reg,
    .tgt_rdata(TDATA), .tgt_stop_req(1'b0), .tgt_wdata_reg, .tgt_be_n_reg, .tgt_wvalid_reg, .tgt_cfg_reg,
    .ad_i(ad), .ad_o, .ad_lo_oe, .ad_hi_oe, .cbe_n_i(cbe), .cbe_n_o, .cbe_lo_oe, .cbe_hi_oe,
    .par_i(par_oe ? par_o : par_q), .par_o, .par_oe, .par64_i(par64_oe ? par64_o : par64_q), .par64_o, .par64_oe,
    .frame_n_i(frame_n), .frame_n_o, .frame_oe, .irdy_n_i(irdy_n), .irdy_n_o, .irdy_oe, .trdy_n_i(trdy_n), .trdy_n_o,
    .trdy_oe, .stop_n_i(stop_oe ? stop_n_o : 1'b1), .stop_n_o, .stop_oe, .devsel_n_i(devsel_n), .devsel_n_o,
    .devsel_oe, .idsel_i(idsel));
  pcims_peer u_pcims_peer (.mclk, .frame_n, .irdy_n, .ad, .cbe_n(cbe), .ad_p(p_ad), .ad_p_oe(p_ad_oe),
    .trdy_n(p_trdy_n), .devsel_n(p_devsel_n), .en(p_en), .lat(p_lat), .rdata(RDATA), .addr(p_addr),
    .cmd(p_cmd), .wdata(p_wdata), .be_n(p_be_n));
  task chk(input [63:0] got, input [63:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // device as master: one request, answer judged from the peer's capture and the read response
  task m_xfer(input [3:0] cmd, input [63:0] addr, input abort);
    integer i;
    begin
      mreq_cmd = cmd;
      mreq_addr = addr;
      mreq_valid = 1'b1;
      for (i = 0; i < 20 && !mreq_ready; i = i + 1) #10;
      @(posedge mclk);
      #1 mreq_valid = 1'b0;
      for (i = 0; i < 40 && mrsp_valid_reg !== 1'b1 && mrsp_abort_reg !== 1'b1; i = i + 1) #10;
      chk(mrsp_abort_reg, abort);
      if (!abort) begin
        chk(p_addr & msk, addr & msk);
        chk(p_cmd, cmd);
        chk((cmd[0] ? p_wdata : mrsp_rdata_reg) & msk, (cmd[0] ? ~addr : RDATA) & msk);
        chk(p_be_n, bus64 ? addr[7:0] : {4'hF, addr[3:0]});
      end
      repeat (4) @(posedge mclk);
      #1 $display("master test cmd %h done", cmd);
    end
  endtask
  // device as target: bench starts one single-phase cycle
  task h_xfer(input [3:0] cmd, input sel, input [63:0] addr, input claim);
    integer i;
    reg hit;
    begin
      hit = 1'b0;
      b_frame_n = 1'b0;
      b_cbe = {4'h0, cmd};
      b_ad = addr;
      b_ad_oe = 1'b1;
      idsel = sel;
      @(posedge mclk);
      #1 b_frame_n = 1'b1; // single phase is the final one
      b_irdy_n = 1'b0;
      b_cbe = 8'h00;
      b_ad = ~TDATA;
      b_ad_oe = cmd[0];
      idsel = 1'b0;
      for (i = 0; i < 16 && !hit; i = i + 1) begin
        @(posedge mclk);
        #1 hit = !trdy_n && !devsel_n;
      end
      if (hit && !cmd[0]) chk(ad, TDATA);
      @(posedge mclk);
      #1 b_irdy_n = 1'b1;
      b_ad_oe = 1'b0;
      b_cbe = 8'hFF;
      chk(hit, claim);
      repeat (6) @(posedge mclk);
      if (claim && cmd[0]) chk(tgt_wdata_reg, ~TDATA);
      if (claim && cmd[0]) chk(tgt_be_n_reg, 8'h00);
      if (claim) chk(tgt_cfg_reg, sel);
      #1 $display("target test cmd %h sel %b done", cmd, sel);
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    for (k = 0; k < 4; k = k + 1) begin
      p_lat = k * 3; // prompt and slow answers
      m_xfer(k[1] ? `PCIMS_CMD_IO_RD | k[0] : `PCIMS_CMD_MEM_RD | k[0], 64'h0000_1230_0000_0040 + k, 1'b0);
    end
    p_en = 1'b0; // nobody claims: abort expected
    m_xfer(`PCIMS_CMD_MEM_RD, 64'h0000_0000_0000_0080, 1'b1);
    h_xfer(`PCIMS_CMD_CFG_RD, 1'b1, 64'h0000_0000_0000_0010, 1'b1);
    h_xfer(`PCIMS_CMD_CFG_RD, 1'b0, 64'h0000_0000_0000_0010, 1'b0);
    h_xfer(`PCIMS_CMD_CFG_WR, 1'b1, 64'h0000_0000_0000_0014, 1'b1);
    h_xfer(`PCIMS_CMD_MEM_WR, 1'b0, 64'h0000_0000_0000_0040, 1'b1);
    h_xfer(`PCIMS_CMD_MEM_RD, 1'b0, 64'h0000_0000_0001_0000, 1'b0);
    p_en = 1'b1;
    bus64 = 1'b0; // narrow bus, low half only
    m_xfer(`PCIMS_CMD_MEM_WR, 64'h0000_0000_0000_00A7, 1'b0);
    m_xfer(`PCIMS_CMD_MEM_RD, 64'h0000_0000_0000_00C3, 1'b0);
    tally_and_finish;
  end
endmodule // testbench
